// ### inc/pbm_pkg.sv
// Notes on behaviour
// - Ten independent channels, 0 to 9, each with control, pointer and count.
// - Elements move as byte, half-word or word, memory to peripheral or back.
// - One element moves per peripheral request pulse; each further element needs a fresh one.
// - System bus ownership is given up after every single element.
// - Memory accesses raise a bus request and wait for grant before driving.
// - Peripheral data uses the peripheral bus; a simple arbiter shares it with the CPU.
// - Every channel holds a 32-bit memory pointer.
// - Pointer advances by 1, 2 or 4 after each element, by size.
// - Each channel has a 16-bit read/write count, minus one per element.
// - At count zero the channel stops and ignores requests until reloaded.
// - Zero count ignores requests; writing non-zero arms the channel.
// - Reading the count returns the live number of elements left.
// - Rewriting the pointer mid-block makes later elements use the new address.
// - Rewriting the count mid-block makes counting continue from the new value.
// - Block end is a done signal to the peripheral; no status register here.
// - One block carries at most 64 Kbytes.
// - Each channel has a programmable peripheral register address.
// - Direction bit 1 means memory to peripheral, 0 peripheral to memory.
package pbm_pkg;
	localparam int PBM_NUM_CH = 10;
	localparam int PBM_ADDR_W = 12;
	localparam int PBM_COUNT_W = 16;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [11:0] PBM_REG_BASE = 12'h080;
	localparam logic [11:0] PBM_CH_STRIDE = 12'h010;
	localparam logic [1:0] PBM_FLD_PER_ADDR = 2'h0;
	localparam logic [1:0] PBM_FLD_CONTROL = 2'h1;
	localparam logic [1:0] PBM_FLD_MEM_PTR = 2'h2;
	localparam logic [1:0] PBM_FLD_COUNT = 2'h3;
	localparam logic [31:0] PBM_PER_ADDR_RST = 32'hffe00000;
	localparam logic [2:0] PBM_CONTROL_RST = 3'h0;
	localparam logic [31:0] PBM_MEM_PTR_RST = 32'h00000000;
	localparam logic [15:0] PBM_COUNT_RST = 16'h0000;

	// ----------------------------------------
	// Control fields and sizes
	// ----------------------------------------
	localparam int PBM_DIR_BIT = 0;
	localparam int PBM_SIZE_LSB = 1;
	localparam logic [1:0] PBM_SIZE_BYTE = 2'h0;
	localparam logic [1:0] PBM_SIZE_HALF = 2'h1;
	localparam logic [1:0] PBM_SIZE_WORD = 2'h2;
	localparam logic [31:0] PBM_STEP_BYTE = 32'h1;
	localparam logic [31:0] PBM_STEP_HALF = 32'h2;
	localparam logic [31:0] PBM_STEP_WORD = 32'h4;
	// Largest counts that keep a block within 64 Kbytes
	localparam logic [15:0] PBM_MAX_CNT_BYTE = 16'hffff;
	localparam logic [15:0] PBM_MAX_CNT_HALF = 16'h8000;
	localparam logic [15:0] PBM_MAX_CNT_WORD = 16'h4000;

	localparam logic [1:0] PBM_RESP_OKAY = 2'h0;
	localparam logic [1:0] PBM_RESP_SLVERR = 2'h2;

	typedef enum logic [6:0] {
		PBM_ST_IDLE = 7'b0000001,
		PBM_ST_LOAD = 7'b0000010,
		PBM_ST_BUS_REQ = 7'b0000100,
		PBM_ST_BUS_XFER = 7'b0001000,
		PBM_ST_PER_SETUP = 7'b0010000,
		PBM_ST_PER_ACCESS = 7'b0100000,
		PBM_ST_DONE = 7'b1000000
	} pbm_state_e;
endpackage : pbm_pkg

// ### hdl/pbm_addr_store.sv
`timescale 1ns/1ps
// Peripheral address words, one per channel, two registered read ports
module pbm_addr_store #(
	parameter int DEPTH = 10,
	parameter int IDX_W = 4,
	parameter logic [31:0] RESET_WORD = 32'h0
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Write port
	input wire logic wr_en,
	input wire logic [IDX_W-1:0] wr_idx,
	input wire logic [31:0] wr_data,
	input wire logic [3:0] wr_be,
	// Read ports
	input wire logic [IDX_W-1:0] ra_idx,
	output logic [31:0] ra_data,
	input wire logic [IDX_W-1:0] rb_idx,
	output logic [31:0] rb_data
);
	logic [31:0] mem [DEPTH];

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= RESET_WORD;
			end
		end else if (wr_en && (int'(wr_idx) < DEPTH)) begin
			for (int b = 0; b < 4; b++) begin
				if (wr_be[b]) begin
					mem[wr_idx][8*b +: 8] <= wr_data[8*b +: 8];
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ra_data <= RESET_WORD;
			rb_data <= RESET_WORD;
		end else begin
			ra_data <= (int'(ra_idx) < DEPTH) ? mem[ra_idx] : RESET_WORD;
			rb_data <= (int'(rb_idx) < DEPTH) ? mem[rb_idx] : RESET_WORD;
		end
	end
endmodule : pbm_addr_store

// ### hdl/pbm_mover.sv
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pbm_mover import pbm_pkg::*; #(
	parameter int NUM_CH = PBM_NUM_CH,
	parameter int ADDR_W = PBM_ADDR_W
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Register bus, AXI4-Lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Peripheral requests and block ends
	input wire logic [NUM_CH-1:0] xfer_request,
	output logic [NUM_CH-1:0] block_done_signal,
	// System bus master
	output logic sys_req,
	input wire logic sys_grant,
	output logic sys_valid,
	output logic sys_write,
	output logic [1:0] sys_size,
	output logic [31:0] sys_addr,
	output logic [31:0] sys_wdata,
	input wire logic [31:0] sys_rdata,
	input wire logic sys_ready,
	// Peripheral bus master and arbiter
	input wire logic per_cpu_req,
	output logic per_cpu_gnt,
	output logic per_sel,
	output logic per_enable,
	output logic per_write,
	output logic [31:0] per_addr,
	output logic [31:0] per_wdata,
	input wire logic [31:0] per_rdata
);
	localparam int IDX_W = 4;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Returns {hit, channel, field}
	function automatic logic [6:0] reg_decode(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] off;
		logic hit;
		off = a - ADDR_W'(PBM_REG_BASE);
		hit = (a >= ADDR_W'(PBM_REG_BASE)) && (a[1:0] == 2'h0)
			&& (int'(off) < NUM_CH * int'(PBM_CH_STRIDE));
		return {hit, off[7:4], off[3:2]};
	endfunction : reg_decode

	function automatic logic [31:0] size_step(input logic [1:0] sz);
		case (sz)
			PBM_SIZE_BYTE: size_step = PBM_STEP_BYTE;
			PBM_SIZE_HALF: size_step = PBM_STEP_HALF;
			default: size_step = PBM_STEP_WORD;
		endcase
	endfunction : size_step

	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be);
		for (int b = 0; b < 4; b++) begin
			merge_be[8*b +: 8] = be[b] ? nw[8*b +: 8] : old[8*b +: 8];
		end
	endfunction : merge_be

	// ----------------------------------------
	// State
	// ----------------------------------------
	pbm_state_e state;
	logic [2:0] control [NUM_CH];
	logic [31:0] mem_ptr [NUM_CH];
	logic [PBM_COUNT_W-1:0] count [NUM_CH];
	logic [NUM_CH-1:0] pending;
	logic [IDX_W-1:0] cur_ch;
	logic [31:0] data_buf;
	logic rd_wait;
	logic rd_hit;
	logic [IDX_W-1:0] rd_ch;
	logic [1:0] rd_fld;
	logic [6:0] wr_dec;
	logic [6:0] rd_dec;
	logic wr_fire;
	logic [NUM_CH-1:0] nonzero;
	logic [NUM_CH-1:0] avail;
	logic [IDX_W-1:0] sel_ch;
	logic [31:0] per_addr_rd;
	logic [31:0] per_addr_eng;
	logic cur_dir;
	logic [1:0] cur_size;
	logic [31:0] cur_ptr;
	logic [PBM_COUNT_W-1:0] cur_cnt;
	logic step_done;
	logic [31:0] merged;
	logic [PBM_COUNT_W-1:0] cnt_wr_val;
	logic [31:0] cnt_merged;

	assign wr_dec = reg_decode(s_axi_awaddr);
	assign rd_dec = reg_decode(s_axi_araddr);
	// Write lands at the edge where both address and data are taken
	assign wr_fire = s_axi_awready;
	assign cur_dir = control[cur_ch][PBM_DIR_BIT];
	assign cur_size = control[cur_ch][PBM_SIZE_LSB +: 2];
	assign cur_ptr = mem_ptr[cur_ch];
	assign cur_cnt = count[cur_ch];
	assign step_done = (state == PBM_ST_DONE);
	assign avail = pending & nonzero;

	always_comb begin
		merged = merge_be(mem_ptr[wr_dec[5:2]], s_axi_wdata, s_axi_wstrb);
		cnt_merged = merge_be({16'h0, count[wr_dec[5:2]]}, s_axi_wdata, s_axi_wstrb);
		cnt_wr_val = cnt_merged[PBM_COUNT_W-1:0];
		// counts beyond 64 Kbytes are clamped
		case (control[wr_dec[5:2]][PBM_SIZE_LSB +: 2])
			PBM_SIZE_BYTE: cnt_wr_val = (cnt_wr_val > PBM_MAX_CNT_BYTE) ? PBM_MAX_CNT_BYTE : cnt_wr_val;
			PBM_SIZE_HALF: cnt_wr_val = (cnt_wr_val > PBM_MAX_CNT_HALF) ? PBM_MAX_CNT_HALF : cnt_wr_val;
			default: cnt_wr_val = (cnt_wr_val > PBM_MAX_CNT_WORD) ? PBM_MAX_CNT_WORD : cnt_wr_val;
		endcase
	end

	always_comb begin
		nonzero = '0;
		sel_ch = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			nonzero[i] = (count[i] != PBM_COUNT_RST);
		end
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (avail[i]) begin
				sel_ch = IDX_W'(i);
			end
		end
	end

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= PBM_RESP_OKAY;
		end else begin
			s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_dec[6] ? PBM_RESP_OKAY : PBM_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= PBM_RESP_OKAY;
			rd_wait <= 1'b0;
			rd_hit <= 1'b0;
			rd_ch <= '0;
			rd_fld <= PBM_FLD_PER_ADDR;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !rd_wait && !s_axi_rvalid;
			rd_wait <= s_axi_arready;
			if (s_axi_arready) begin
				rd_hit <= rd_dec[6];
				rd_ch <= rd_dec[5:2];
				rd_fld <= rd_dec[1:0];
			end
			if (rd_wait) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= rd_hit ? PBM_RESP_OKAY : PBM_RESP_SLVERR;
				if (!rd_hit) begin
					s_axi_rdata <= 32'h0;
				end else begin
					case (rd_fld)
						PBM_FLD_PER_ADDR: s_axi_rdata <= per_addr_rd;
						PBM_FLD_CONTROL: s_axi_rdata <= {29'h0, control[rd_ch]};
						PBM_FLD_MEM_PTR: s_axi_rdata <= mem_ptr[rd_ch];
						default: s_axi_rdata <= {16'h0, count[rd_ch]};
					endcase
				end
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	pbm_addr_store #(
		.DEPTH(NUM_CH),
		.IDX_W(IDX_W),
		.RESET_WORD(PBM_PER_ADDR_RST)
	) u_addr_store (
		.core_clk(core_clk),
		.resetn(resetn),
		.wr_en(wr_fire && wr_dec[6] && (wr_dec[1:0] == PBM_FLD_PER_ADDR)),
		.wr_idx(wr_dec[5:2]),
		.wr_data(s_axi_wdata),
		.wr_be(s_axi_wstrb),
		.ra_idx(rd_dec[5:2]),
		.ra_data(per_addr_rd),
		.rb_idx(cur_ch),
		.rb_data(per_addr_eng)
	);

	// ----------------------------------------
	// Channel registers
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		for (int i = 0; i < NUM_CH; i++) begin
			if (!resetn) begin
				control[i] <= PBM_CONTROL_RST;
				mem_ptr[i] <= PBM_MEM_PTR_RST;
				count[i] <= PBM_COUNT_RST;
			end else begin
				if (wr_fire && wr_dec[6] && wr_dec[5:2] == IDX_W'(i)
						&& wr_dec[1:0] == PBM_FLD_CONTROL && s_axi_wstrb[0]) begin
					control[i] <= s_axi_wdata[2:0];
				end
				// software write takes over the live pointer
				if (wr_fire && wr_dec[6] && wr_dec[5:2] == IDX_W'(i)
						&& wr_dec[1:0] == PBM_FLD_MEM_PTR) begin
					mem_ptr[i] <= merged;
				end else if (step_done && cur_ch == IDX_W'(i)) begin
					mem_ptr[i] <= mem_ptr[i] + size_step(control[i][PBM_SIZE_LSB +: 2]);
				end
				// software write takes over the live count
				if (wr_fire && wr_dec[6] && wr_dec[5:2] == IDX_W'(i)
						&& wr_dec[1:0] == PBM_FLD_COUNT) begin
					count[i] <= cnt_wr_val;
				end else if (step_done && cur_ch == IDX_W'(i) && nonzero[i]) begin
					count[i] <= count[i] - 16'h1;
				end
			end
		end
	end

	// ----------------------------------------
	// Requests and block end
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			pending <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				// zero count drops requests; a new pulse beats the clear
				pending[i] <= ((pending[i] && !(step_done && cur_ch == IDX_W'(i)))
					|| xfer_request[i]) && nonzero[i];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			block_done_signal <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				// pulse when the last element completes
				block_done_signal[i] <= step_done && cur_ch == IDX_W'(i)
					&& count[i] == 16'h1
					&& !(wr_fire && wr_dec[6] && wr_dec[5:2] == IDX_W'(i)
					&& wr_dec[1:0] == PBM_FLD_COUNT);
			end
		end
	end

	// ----------------------------------------
	// Transfer engine
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state <= PBM_ST_IDLE;
			cur_ch <= '0;
			data_buf <= 32'h0;
			sys_req <= 1'b0;
			sys_valid <= 1'b0;
			sys_write <= 1'b0;
			sys_size <= PBM_SIZE_BYTE;
			sys_addr <= 32'h0;
			sys_wdata <= 32'h0;
			per_cpu_gnt <= 1'b1;
			per_sel <= 1'b0;
			per_enable <= 1'b0;
			per_write <= 1'b0;
			per_addr <= 32'h0;
			per_wdata <= 32'h0;
		end else begin
			case (state)
				PBM_ST_IDLE: begin
					if (|avail) begin
						cur_ch <= sel_ch;
						state <= PBM_ST_LOAD;
					end
				end
				PBM_ST_LOAD: begin
					// direction picks which side goes first
					if (cur_dir) begin
						state <= PBM_ST_BUS_REQ;
						sys_req <= 1'b1;
					end else begin
						state <= PBM_ST_PER_SETUP;
					end
				end
				PBM_ST_BUS_REQ: begin
					if (sys_grant) begin
						sys_valid <= 1'b1;
						sys_write <= !cur_dir;
						sys_size <= cur_size;
						sys_addr <= cur_ptr;
						sys_wdata <= data_buf;
						state <= PBM_ST_BUS_XFER;
					end
				end
				PBM_ST_BUS_XFER: begin
					if (sys_ready) begin
						// bus let go after each element
						sys_valid <= 1'b0;
						sys_req <= 1'b0;
						if (cur_dir) begin
							data_buf <= sys_rdata;
							state <= PBM_ST_PER_SETUP;
						end else begin
							state <= PBM_ST_DONE;
						end
					end
				end
				PBM_ST_PER_SETUP: begin
					// the CPU keeps the peripheral bus while it asks
					if (!per_cpu_req) begin
						per_cpu_gnt <= 1'b0;
						per_sel <= 1'b1;
						per_write <= cur_dir;
						per_addr <= per_addr_eng;
						per_wdata <= data_buf;
						state <= PBM_ST_PER_ACCESS;
					end
				end
				PBM_ST_PER_ACCESS: begin
					if (!per_enable) begin
						per_enable <= 1'b1;
					end else begin
						per_sel <= 1'b0;
						per_enable <= 1'b0;
						per_cpu_gnt <= 1'b1;
						if (cur_dir) begin
							state <= PBM_ST_DONE;
						end else begin
							data_buf <= per_rdata;
							sys_req <= 1'b1;
							state <= PBM_ST_BUS_REQ;
						end
					end
				end
				PBM_ST_DONE: begin
					state <= PBM_ST_IDLE;
				end
				default: begin
					state <= PBM_ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_bus_released: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(state == PBM_ST_DONE) |-> !sys_req && !sys_valid)
		else $error("system bus held past an element");

	a_grant_first: assert property (
		@(posedge core_clk) disable iff (!resetn)
		$rose(sys_valid) |-> sys_req && $past(sys_grant))
		else $error("system access driven without grant");

	a_ptr_step: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(state == PBM_ST_DONE && !wr_fire) |=> cur_ptr == $past(cur_ptr) + size_step($past(cur_size)))
		else $error("pointer did not advance by element size");

	a_cnt_dec: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(state == PBM_ST_DONE && !wr_fire && cur_cnt != 16'h0) |=> cur_cnt == $past(cur_cnt) - 16'h1)
		else $error("count did not drop by one");

	a_zero_ignored: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(state == PBM_ST_IDLE && avail == '0) |=> state == PBM_ST_IDLE)
		else $error("transfer began without an armed request");

	a_done_pulse: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(|block_done_signal) |-> $past(state) == PBM_ST_DONE && $past(cur_cnt) == 16'h1)
		else $error("block end signalled at the wrong time");

	a_one_element: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(state == PBM_ST_DONE && !xfer_request[cur_ch])
			|=> state == PBM_ST_IDLE && !pending[cur_ch])
		else $error("request not retired after one element");

	a_lowest_first: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(state == PBM_ST_IDLE && avail[0]) |=> state == PBM_ST_LOAD && cur_ch == 4'h0)
		else $error("channel zero not served first");

	a_per_owner: assert property (
		@(posedge core_clk) disable iff (!resetn)
		per_sel |-> !per_cpu_gnt ##1 (per_sel && per_enable) || !per_sel)
		else $error("peripheral bus shared during an access");
endmodule : pbm_mover

// ### test/pbm_far_model.sv
`timescale 1ns/1ps
// System bus arbiter with memory, and the peripheral data registers
module pbm_far_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// System bus slave side
	input wire logic sys_req,
	output logic sys_grant,
	input wire logic sys_valid,
	input wire logic [31:0] sys_addr,
	output logic [31:0] sys_rdata,
	output logic sys_ready,
	// Peripheral data registers
	input wire logic per_enable,
	input wire logic [31:0] per_addr,
	output logic [31:0] per_rdata
);
	logic [1:0] wait_cnt;

	// ----------------------------------------
	// Arbitration and memory answer
	// ----------------------------------------
	// grant per request
	// Random waits of zero to three cycles, so both prompt and slow answers occur
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sys_grant <= 1'b0;
			sys_ready <= 1'b0;
			wait_cnt <= 2'h0;
		end else begin
			sys_ready <= 1'b0;
			if (!sys_req) begin
				sys_grant <= 1'b0;
				wait_cnt <= 2'($urandom);
			end else if (wait_cnt != 2'h0) begin
				wait_cnt <= wait_cnt - 2'h1;
			end else if (!sys_grant) begin
				sys_grant <= 1'b1;
				wait_cnt <= 2'($urandom);
			end else if (sys_valid && !sys_ready) begin
				sys_ready <= 1'b1;
			end
		end
	end

	// data only while answering
	// Outside the answer the lines carry the inverse, so a stale sample is seen
	assign sys_rdata = sys_ready ? (sys_addr ^ 32'h3c3c0f0f) : ~(sys_addr ^ 32'h3c3c0f0f);
	assign per_rdata = per_enable ? (per_addr ^ 32'h0ff0a55a) : ~(per_addr ^ 32'h0ff0a55a);
endmodule : pbm_far_model

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench import pbm_pkg::*; ;
	typedef struct packed {logic [31:0] addr; logic [1:0] size; logic wr; logic [31:0] paddr;} pbm_exp_s;
	logic core_clk, resetn;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, sys_addr, sys_wdata, sys_rdata, per_addr, per_wdata, per_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, sys_size;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [9:0] xfer_request, block_done_signal;
	logic sys_req, sys_grant, sys_valid, sys_write, sys_ready;
	logic per_cpu_req, per_cpu_gnt, per_sel, per_enable, per_write;
	logic [31:0] ptr[10], pa[10];
	logic [2:0] ctl[10];
	logic [15:0] cnt[10];
	pbm_exp_s xq[$];
	logic [9:0] dq[$];
	logic [1:0] bq[$];
	logic [33:0] rq[$];
	int err_total = 0;
	int num_checks = 0;
	bit hf, rel;

	pbm_mover dut (.core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .xfer_request, .block_done_signal, .sys_req, .sys_grant,
		.sys_valid, .sys_write, .sys_size, .sys_addr, .sys_wdata, .sys_rdata, .sys_ready,
		.per_cpu_req, .per_cpu_gnt, .per_sel, .per_enable, .per_write, .per_addr, .per_wdata,
		.per_rdata);
	pbm_far_model far (.core_clk, .resetn, .sys_req, .sys_grant, .sys_valid, .sys_addr,
		.sys_rdata, .sys_ready, .per_enable, .per_addr, .per_rdata);

	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic check(input logic [33:0] seen, input logic [33:0] want);
		num_checks++;
		if (seen !== want) begin
			err_total++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic stop_test;
		if (err_total == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test

	task automatic step(inout int n);
		@(posedge core_clk);
		n++;
		if (n > 2000) begin
			err_total++;
			stop_test();
		end
	endtask : step

	// ----------------------------------------
	// Register bus master
	// ----------------------------------------
	function automatic logic [11:0] ra(input int ch, input logic [1:0] f);
		return PBM_REG_BASE + 12'(ch) * PBM_CH_STRIDE + {8'h00, f, 2'b00};
	endfunction : ra

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		int n = 0;
		bit aw_open = 1'b1;
		bit w_open = 1'b1;
		bq.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		// Each channel is released at its own ready
		do begin
			step(n);
			if (aw_open && s_axi_awready) begin
				aw_open = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w_open && s_axi_wready) begin
				w_open = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end while (aw_open || w_open);
		do step(n); while (!s_axi_bvalid);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		int n = 0;
		rq.push_back({r, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do step(n); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do step(n); while (!s_axi_rvalid);
	endtask : rd

	task automatic setreg(input int ch, input logic [1:0] f, input logic [31:0] d);
		logic [15:0] mx;
		wr(ra(ch, f), d, PBM_RESP_OKAY);
		mx = ctl[ch][2:1] == PBM_SIZE_BYTE ? PBM_MAX_CNT_BYTE
			: ctl[ch][2:1] == PBM_SIZE_HALF ? PBM_MAX_CNT_HALF : PBM_MAX_CNT_WORD;
		case (f)
			PBM_FLD_PER_ADDR: pa[ch] = d;
			PBM_FLD_CONTROL: ctl[ch] = d[2:0];
			PBM_FLD_MEM_PTR: ptr[ch] = d;
			default: cnt[ch] = d[15:0] > mx ? mx : d[15:0];
		endcase
	endtask : setreg

	task automatic cfg(input int ch, input logic [31:0] p, input logic [2:0] c,
		input logic [31:0] m, input logic [15:0] k);
		setreg(ch, PBM_FLD_PER_ADDR, p);
		setreg(ch, PBM_FLD_CONTROL, {29'h0, c});
		setreg(ch, PBM_FLD_MEM_PTR, m);
		setreg(ch, PBM_FLD_COUNT, {16'h0, k});
	endtask : cfg

	// ----------------------------------------
	// Peripheral requests and expectations
	// ----------------------------------------
	// lowest channel noted first
	task automatic req(input logic [9:0] mk);
		for (int i = 0; i < 10; i++) begin
			if (mk[i] && cnt[i] != 16'h0) begin
				xq.push_back({ptr[i], ctl[i][2:1], !ctl[i][0], pa[i]});
				ptr[i] = ptr[i] + (32'h1 << ctl[i][2:1]);
				cnt[i] = cnt[i] - 16'h1;
				if (cnt[i] == 16'h0) dq.push_back(10'h001 << i);
			end
		end
		xfer_request <= mk;
		@(posedge core_clk);
		xfer_request <= 10'h000;
	endtask : req

	task automatic drain;
		int n = 0;
		while (xq.size() != 0 || dq.size() != 0) step(n);
		repeat (4) @(posedge core_clk);
	endtask : drain

	// ----------------------------------------
	// Output monitor
	// ----------------------------------------
	// Each element has two halves; the later one retires the note
	always @(posedge core_clk) begin
		if (resetn) begin
			if (rel) check(sys_req, 1'b0);
			rel = sys_valid && sys_ready;
			if (s_axi_bvalid && s_axi_bready) check(s_axi_bresp, bq.size() ? bq.pop_front() : 2'h3);
			if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rq.size() ? rq.pop_front() : 34'h300000000);
			if (|block_done_signal) check(block_done_signal, dq.size() ? dq.pop_front() : 10'h000);
			if (sys_valid && sys_ready) begin
				check(sys_grant, 1'b1);
				check({sys_addr, sys_size, sys_write}, {xq[0].addr, xq[0].size, xq[0].wr});
				if (sys_write && xq[0].size == PBM_SIZE_WORD) check(sys_wdata, xq[0].paddr ^ 32'h0ff0a55a);
			end
			if (per_enable) begin
				check(per_cpu_gnt, 1'b0);
				check(per_sel, 1'b1);
				check({per_addr, per_write}, {xq[0].paddr, !xq[0].wr});
				if (per_write && xq[0].size == PBM_SIZE_WORD) check(per_wdata, xq[0].addr ^ 32'h3c3c0f0f);
			end
			if ((sys_valid && sys_ready) || per_enable) begin
				if (hf) void'(xq.pop_front());
				hf = !hf;
			end
		end
	end

	// Peripheral bus contention from the processor side
	always @(posedge core_clk) per_cpu_req <= ($urandom % 4) == 0;

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		int c;
		void'($urandom(77));
		{resetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, xfer_request} = '0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
		for (int k = 0; k < 10; k++) begin
			{pa[k], ctl[k], ptr[k], cnt[k]} = {PBM_PER_ADDR_RST, 3'h0, 32'h0, 16'h0};
		end
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		for (int k = 0; k < 10; k++) begin
			rd(ra(k, PBM_FLD_PER_ADDR), PBM_PER_ADDR_RST, PBM_RESP_OKAY);
			rd(ra(k, PBM_FLD_COUNT), 32'h0, PBM_RESP_OKAY);
		end
		rd(ra(9, PBM_FLD_CONTROL), 32'h0, PBM_RESP_OKAY);
		rd(ra(9, PBM_FLD_MEM_PTR), 32'h0, PBM_RESP_OKAY);
		rd(12'h000, 32'h0, PBM_RESP_SLVERR);
		rd(12'h082, 32'h0, PBM_RESP_SLVERR);
		wr(12'h120, 32'h1, PBM_RESP_SLVERR);
		req(10'h008);
		repeat (20) @(posedge core_clk);
		for (int k = 0; k < 4; k++) begin
			c = k * 3;
			cfg(c, $urandom & 32'hfffffffc, {k == 3 ? 2'h2 : 2'(k), k[0]}, $urandom & 32'hfffffff0, 16'h2);
			repeat (3) begin
				req(10'h001 << c);
				drain();
			end
			rd(ra(c, PBM_FLD_COUNT), 32'h0, PBM_RESP_OKAY);
		end
		cfg(4, 32'hfffb0084, 3'b101, 32'h20000000, 16'h3);
		req(10'h010);
		drain();
		rd(ra(4, PBM_FLD_COUNT), 32'h2, PBM_RESP_OKAY);
		setreg(4, PBM_FLD_MEM_PTR, 32'h30000000);
		setreg(4, PBM_FLD_COUNT, 32'h2);
		repeat (2) begin
			req(10'h010);
			drain();
		end
		cfg(1, 32'hfffa8084, 3'b011, 32'h00000100, 16'h1);
		cfg(8, 32'hfffb8080, 3'b000, 32'h48000000, 16'h1);
		req(10'h102);
		drain();
		setreg(2, PBM_FLD_CONTROL, 32'h4);
		setreg(2, PBM_FLD_COUNT, 32'hffff);
		rd(ra(2, PBM_FLD_COUNT), {16'h0, PBM_MAX_CNT_WORD}, PBM_RESP_OKAY);
		stop_test();
	end
endmodule : testbench
